// ==== rtl/bridge_command_id_header.sv ====
// identity words, command word and two primary status flags of a bridge port
`timescale 1ns/1ns
`default_nettype none
module bridge_command_id_header #(
  parameter logic [15:0] maker_identity = bridge_cmd_pkg::maker_identity_default,
  parameter logic [15:0] part_identity = bridge_cmd_pkg::part_identity_default
) (
  input wire logic sys_clk,
  input wire logic rst,
  // configuration requests from the primary side, dword addressed
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [9:0] cfg_dw_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // primary-side requests hitting the windows
  input wire logic pri_req_valid,
  input wire logic io_window_hit,
  input wire logic mem_window_hit,
  input wire logic prefetch_window_hit,
  output logic pri_claim,
  // requests from below the bridge
  input wire logic sec_req_valid,
  input wire logic [1:0] sec_req_kind,
  input wire logic sec_req_nonposted,
  output logic up_forward,
  output logic ur_reply,
  output logic req_dropped,
  // poisoned traffic on the primary side
  input wire logic poisoned_cpl_rx,
  input wire logic poisoned_wr_tx,
  // error detection and messages
  input wire logic own_fatal_det,
  input wire logic own_nonfatal_det,
  input wire logic dev_fatal_report_en,
  input wire logic dev_nonfatal_report_en,
  input wire logic sec_err_cor_rx,
  input wire logic sec_err_nonfatal_rx,
  input wire logic sec_err_fatal_rx,
  output logic err_cor_send,
  output logic err_nonfatal_send,
  output logic err_fatal_send,
  // legacy interrupts
  input wire logic [3:0] own_irq_level,
  input wire logic [3:0] sec_intx_level,
  output logic [3:0] intx_state,
  output logic intx_msg_valid,
  output logic intx_msg_assert,
  output logic [1:0] intx_msg_lane,
  // command bits and status flags for the rest of the port
  output logic io_space_respond_en,
  output logic mem_space_respond_en,
  output logic request_forward_en,
  output logic poison_report_en,
  output logic error_report_en,
  output logic legacy_irq_mask,
  output logic master_poison_flag,
  output logic system_error_sent
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic dw_hit(input logic [9:0] addr, input logic [11:0] off);
    dw_hit = (addr == off[11:2]);
  endfunction

  function automatic logic [3:0] low_lane(input logic [3:0] vec);
    low_lane = vec & (~vec + 4'h1);
  endfunction

  logic cfg_wr;
  logic cfg_rd;
  logic hit_id;
  logic hit_cmd;
  logic [15:0] command_word;
  logic [15:0] status_word;

  assign cfg_wr = cfg_req && cfg_we;
  assign cfg_rd = cfg_req && !cfg_we;
  assign hit_id = dw_hit(cfg_dw_addr, bridge_cmd_pkg::maker_identity_off);
  assign hit_cmd = dw_hit(cfg_dw_addr, bridge_cmd_pkg::bridge_command_off);

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  // low byte holds the three respond/forward enables and poison report
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      io_space_respond_en <= bridge_cmd_pkg::bridge_command_reset[0];
      mem_space_respond_en <= bridge_cmd_pkg::bridge_command_reset[1];
      request_forward_en <= bridge_cmd_pkg::bridge_command_reset[2];
      poison_report_en <= bridge_cmd_pkg::bridge_command_reset[6];
    end
    else if (cfg_wr && hit_cmd && cfg_be[0])
    begin
      io_space_respond_en <= cfg_wdata[bridge_cmd_pkg::io_space_respond_en_bit];
      mem_space_respond_en <= cfg_wdata[bridge_cmd_pkg::mem_space_respond_en_bit];
      request_forward_en <= cfg_wdata[bridge_cmd_pkg::request_forward_en_bit];
      poison_report_en <= cfg_wdata[bridge_cmd_pkg::poison_report_en_bit];
    end
  end

  // second byte holds error report enable and the interrupt mask
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      error_report_en <= bridge_cmd_pkg::bridge_command_reset[8];
      legacy_irq_mask <= bridge_cmd_pkg::bridge_command_reset[10];
    end
    else if (cfg_wr && hit_cmd && cfg_be[1])
    begin
      error_report_en <= cfg_wdata[bridge_cmd_pkg::error_report_en_bit];
      legacy_irq_mask <= cfg_wdata[bridge_cmd_pkg::legacy_irq_mask_bit];
    end
  end

  // unused bits 3,4,5,7,9 and 15:11 are tied to zero
  always_comb
  begin
    command_word = 16'h0000;
    command_word[bridge_cmd_pkg::io_space_respond_en_bit] = io_space_respond_en;
    command_word[bridge_cmd_pkg::mem_space_respond_en_bit] = mem_space_respond_en;
    command_word[bridge_cmd_pkg::request_forward_en_bit] = request_forward_en;
    command_word[bridge_cmd_pkg::poison_report_en_bit] = poison_report_en;
    command_word[bridge_cmd_pkg::error_report_en_bit] = error_report_en;
    command_word[bridge_cmd_pkg::legacy_irq_mask_bit] = legacy_irq_mask;
  end

  // ----------------------------------------------------------------
  // primary status flags
  // ----------------------------------------------------------------
  logic poison_set;
  logic poison_clear;
  logic syserr_set;
  logic syserr_clear;

  // status sits in the upper half of the command dword; byte 3 carries bits 8 and 14
  assign poison_set = poison_report_en && (poisoned_cpl_rx || poisoned_wr_tx);
  assign poison_clear = cfg_wr && hit_cmd && cfg_be[3] &&
                        cfg_wdata[16 + bridge_cmd_pkg::master_poison_flag_bit];
  assign syserr_clear = cfg_wr && hit_cmd && cfg_be[3] &&
                        cfg_wdata[16 + bridge_cmd_pkg::system_error_sent_bit];

  sticky_flag #(
    .reset_value(bridge_cmd_pkg::master_poison_flag_reset)
  ) u_poison_flag (
    .sys_clk(sys_clk),
    .rst(rst),
    .set_pulse(poison_set),
    .clear_pulse(poison_clear),
    .flag(master_poison_flag)
  );

  sticky_flag #(
    .reset_value(bridge_cmd_pkg::system_error_sent_reset)
  ) u_syserr_flag (
    .sys_clk(sys_clk),
    .rst(rst),
    .set_pulse(syserr_set),
    .clear_pulse(syserr_clear),
    .flag(system_error_sent)
  );

  always_comb
  begin
    status_word = 16'h0000;
    status_word[bridge_cmd_pkg::master_poison_flag_bit] = master_poison_flag;
    status_word[bridge_cmd_pkg::system_error_sent_bit] = system_error_sent;
  end

  // ----------------------------------------------------------------
  // configuration read path
  // ----------------------------------------------------------------
  // identity words are constants, so writes to dword zero simply fall away
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cfg_rdata <= 32'h00000000;
    else if (cfg_rd)
    begin
      if (hit_id)
        cfg_rdata <= {part_identity, maker_identity};
      else if (hit_cmd)
        cfg_rdata <= {status_word, command_word};
      else
        cfg_rdata <= 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cfg_ack <= 1'b0;
    else
      cfg_ack <= cfg_req;
  end

  // ----------------------------------------------------------------
  // window claiming
  // ----------------------------------------------------------------
  // window hits come from base/limit decode outside; enables only gate them
  assign pri_claim = pri_req_valid &&
                     ((io_window_hit && io_space_respond_en) ||
                      ((mem_window_hit || prefetch_window_hit) &&
                       mem_space_respond_en));

  // ----------------------------------------------------------------
  // upstream request forwarding
  // ----------------------------------------------------------------
  request_gate u_request_gate (
    .request_forward_en(request_forward_en),
    .sec_req_valid(sec_req_valid),
    .sec_req_kind(sec_req_kind),
    .sec_req_nonposted(sec_req_nonposted),
    .up_forward(up_forward),
    .ur_reply(ur_reply),
    .req_dropped(req_dropped)
  );

  // ----------------------------------------------------------------
  // error messages
  // ----------------------------------------------------------------
  logic own_fatal_ok;
  logic own_nonfatal_ok;
  logic next_fatal_send;
  logic next_nonfatal_send;

  assign own_fatal_ok = own_fatal_det && (error_report_en || dev_fatal_report_en);
  assign own_nonfatal_ok = own_nonfatal_det &&
                           (error_report_en || dev_nonfatal_report_en);
  // own and forwarded errors of one class merge into one message per cycle
  assign next_fatal_send = own_fatal_ok || (sec_err_fatal_rx && error_report_en);
  assign next_nonfatal_send = own_nonfatal_ok ||
                              (sec_err_nonfatal_rx && error_report_en);
  // a message sent under the device control enables alone leaves bit 14 clear
  assign syserr_set = error_report_en && (next_fatal_send || next_nonfatal_send);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      err_cor_send <= 1'b0;
      err_nonfatal_send <= 1'b0;
      err_fatal_send <= 1'b0;
    end
    else
    begin
      err_cor_send <= sec_err_cor_rx;
      err_nonfatal_send <= next_nonfatal_send;
      err_fatal_send <= next_fatal_send;
    end
  end

  // ----------------------------------------------------------------
  // legacy interrupts
  // ----------------------------------------------------------------
  logic [3:0] own_masked;
  logic [3:0] resolved;
  logic [3:0] changed;
  logic [3:0] pick;
  logic [1:0] pick_lane;

  assign own_masked = own_irq_level & ~{4{legacy_irq_mask}};
  assign resolved = own_masked | sec_intx_level;
  assign changed = resolved ^ intx_state;
  assign pick = low_lane(changed);

  // one message per cycle; further lanes follow on later cycles
  always_comb
  begin
    pick_lane = 2'h0;
    if (pick[1])
      pick_lane = 2'h1;
    else if (pick[2])
      pick_lane = 2'h2;
    else if (pick[3])
      pick_lane = 2'h3;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      intx_state <= 4'h0;
    else
      intx_state <= intx_state ^ pick;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      intx_msg_valid <= 1'b0;
      intx_msg_assert <= 1'b0;
      intx_msg_lane <= 2'h0;
    end
    else
    begin
      intx_msg_valid <= |changed;
      intx_msg_assert <= |(pick & resolved);
      intx_msg_lane <= pick_lane;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/bridge_cmd_pkg.sv ====
// constants for the bridge identity, command and status header words
package bridge_cmd_pkg;

  // ----------------------------------------------------------------
  // configuration offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] maker_identity_off = 12'h000;
  localparam logic [11:0] part_identity_off = 12'h002;
  localparam logic [11:0] bridge_command_off = 12'h004;
  localparam logic [11:0] primary_status_off = 12'h006;

  // ----------------------------------------------------------------
  // bridge_command field positions
  // ----------------------------------------------------------------
  localparam int io_space_respond_en_bit = 0;
  localparam int mem_space_respond_en_bit = 1;
  localparam int request_forward_en_bit = 2;
  localparam int poison_report_en_bit = 6;
  localparam int error_report_en_bit = 8;
  localparam int legacy_irq_mask_bit = 10;
  localparam logic [15:0] bridge_command_reset = 16'h0000;

  // ----------------------------------------------------------------
  // primary_status field positions
  // ----------------------------------------------------------------
  localparam int master_poison_flag_bit = 8;
  localparam int system_error_sent_bit = 14;
  localparam logic master_poison_flag_reset = 1'b0;
  localparam logic system_error_sent_reset = 1'b0;

  // ----------------------------------------------------------------
  // identity defaults, both values arbitrary
  // ----------------------------------------------------------------
  localparam logic [15:0] maker_identity_default = 16'h5a5a;
  localparam logic [15:0] part_identity_default = 16'h0c0d;

  // ----------------------------------------------------------------
  // downstream request kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] kind_mem = 2'h0;
  localparam logic [1:0] kind_io = 2'h1;
  localparam logic [1:0] kind_msg = 2'h2;
  localparam logic [1:0] kind_cpl = 2'h3;

endpackage

// ==== rtl/sticky_flag.sv ====
// write-one-to-clear status flag where a hardware set beats a clear
`timescale 1ns/1ns
`default_nettype none
module sticky_flag #(
  parameter logic reset_value = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      flag <= reset_value;
    else if (set_pulse)
      flag <= 1'b1;
    else if (clear_pulse)
      flag <= 1'b0;
  end

endmodule
`default_nettype wire

// ==== rtl/request_gate.sv ====
// gates requests from below the bridge on the forwarding enable
`timescale 1ns/1ns
`default_nettype none
module request_gate (
  input wire logic request_forward_en,
  input wire logic sec_req_valid,
  input wire logic [1:0] sec_req_kind,
  input wire logic sec_req_nonposted,
  output logic up_forward,
  output logic ur_reply,
  output logic req_dropped
);

  logic gated_kind;

  // only memory and io requests (msi writes count as memory) are gated
  assign gated_kind = (sec_req_kind == bridge_cmd_pkg::kind_mem) ||
                      (sec_req_kind == bridge_cmd_pkg::kind_io);

  // completions and messages always pass
  assign up_forward = sec_req_valid && (request_forward_en || !gated_kind);
  // blocked non-posted requests get an unsupported request completion
  assign ur_reply = sec_req_valid && gated_kind && !request_forward_en &&
                    sec_req_nonposted;
  assign req_dropped = sec_req_valid && gated_kind && !request_forward_en &&
                       !sec_req_nonposted;

endmodule
`default_nettype wire

// ==== dv/bridge_command_id_header_monitor.sv ====
// concurrent checks on the ports of the bridge identity and command header
`timescale 1ns/1ns
`default_nettype none
module bridge_command_id_header_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pri_req_valid,
  input wire logic io_window_hit,
  input wire logic mem_window_hit,
  input wire logic prefetch_window_hit,
  input wire logic pri_claim,
  input wire logic io_space_respond_en,
  input wire logic mem_space_respond_en,
  input wire logic sec_req_valid,
  input wire logic [1:0] sec_req_kind,
  input wire logic sec_req_nonposted,
  input wire logic request_forward_en,
  input wire logic up_forward,
  input wire logic ur_reply,
  input wire logic poisoned_cpl_rx,
  input wire logic poisoned_wr_tx,
  input wire logic poison_report_en,
  input wire logic master_poison_flag,
  input wire logic own_fatal_det,
  input wire logic error_report_en,
  input wire logic err_fatal_send,
  input wire logic system_error_sent,
  input wire logic sec_err_fatal_rx,
  input wire logic sec_err_cor_rx,
  input wire logic err_cor_send,
  input wire logic legacy_irq_mask,
  input wire logic [3:0] own_irq_level,
  input wire logic [3:0] sec_intx_level,
  input wire logic [3:0] intx_state
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  wire logic mem_hit = mem_window_hit || prefetch_window_hit;
  wire logic gated = sec_req_valid && !sec_req_kind[1] && !request_forward_en;
  // four lanes can differ, one settles per cycle, so five samples suffice
  sequence masked_settle;
    (legacy_irq_mask && $stable(sec_intx_level)) [*5];
  endsequence
  sequence open_settle;
    (!legacy_irq_mask && $stable(sec_intx_level) && $stable(own_irq_level)) [*5];
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_io_claim: assert property (pri_req_valid && io_window_hit && !mem_hit
    |-> pri_claim == io_space_respond_en) else $error("io claim wrong");
  a_mem_claim: assert property (pri_req_valid && !io_window_hit && mem_hit
    |-> pri_claim == mem_space_respond_en) else $error("mem claim wrong");
  a_fwd_blocked: assert property (gated |-> !up_forward)
    else $error("blocked request forwarded");
  a_ur_answer: assert property (gated && sec_req_nonposted |-> ur_reply)
    else $error("no unsupported request reply");
  a_other_pass: assert property (sec_req_valid && sec_req_kind[1]
    |-> up_forward && !ur_reply) else $error("message or completion held");
  a_poison_gate: assert property (!poison_report_en && !master_poison_flag
    |=> !master_poison_flag) else $error("poison flag set while disabled");
  a_poison_set: assert property (poison_report_en && (poisoned_cpl_rx || poisoned_wr_tx)
    |=> master_poison_flag) else $error("poison flag not set");
  a_own_report: assert property (own_fatal_det && error_report_en
    |=> err_fatal_send && system_error_sent) else $error("own fatal not reported");
  a_fatal_gate: assert property (sec_err_fatal_rx && !own_fatal_det && !error_report_en
    |=> !err_fatal_send) else $error("fatal forwarded while disabled");
  a_cor_always: assert property (sec_err_cor_rx |=> err_cor_send)
    else $error("correctable message not forwarded");
  a_mask_forwards: assert property (masked_settle |-> intx_state == sec_intx_level)
    else $error("masked interrupt state wrong");
  a_open_resolve: assert property (open_settle
    |-> intx_state == (own_irq_level | sec_intx_level)) else $error("interrupt state wrong");
endmodule
bind bridge_command_id_header bridge_command_id_header_monitor mon (
  .sys_clk(sys_clk), .rst(rst), .pri_req_valid(pri_req_valid),
  .io_window_hit(io_window_hit), .mem_window_hit(mem_window_hit),
  .prefetch_window_hit(prefetch_window_hit), .pri_claim(pri_claim),
  .io_space_respond_en(io_space_respond_en), .mem_space_respond_en(mem_space_respond_en),
  .sec_req_valid(sec_req_valid), .sec_req_kind(sec_req_kind),
  .sec_req_nonposted(sec_req_nonposted), .request_forward_en(request_forward_en),
  .up_forward(up_forward), .ur_reply(ur_reply), .poisoned_cpl_rx(poisoned_cpl_rx),
  .poisoned_wr_tx(poisoned_wr_tx), .poison_report_en(poison_report_en),
  .master_poison_flag(master_poison_flag), .own_fatal_det(own_fatal_det),
  .error_report_en(error_report_en), .err_fatal_send(err_fatal_send),
  .system_error_sent(system_error_sent), .sec_err_fatal_rx(sec_err_fatal_rx),
  .sec_err_cor_rx(sec_err_cor_rx), .err_cor_send(err_cor_send),
  .legacy_irq_mask(legacy_irq_mask), .own_irq_level(own_irq_level),
  .sec_intx_level(sec_intx_level), .intx_state(intx_state)
);
`default_nettype wire

// ==== dv/root_complex_model.sv ====
// root complex model issuing configuration requests to the bridge port
`timescale 1ns/1ns
`default_nettype none
module root_complex_model (
  input wire logic sys_clk,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_req,
  output logic cfg_we,
  output logic [9:0] cfg_dw_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  initial
  begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_dw_addr = 10'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  // one-cycle request pulse; the answer must stand at the very next edge
  task automatic access(input logic we, input logic [9:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] q);
    q = 'x;
    @(negedge sys_clk);
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_dw_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge sys_clk);
    cfg_req = 1'b0;
    // a late or missing acknowledge leaves q unknown, so rd flags it; wr never checks q
    if (cfg_ack === 1'b1)
      q = cfg_rdata;
    // stale data must not look valid once the access is over
    cfg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ==== dv/bridge_command_id_header_tb_top.sv ====
// self-checking bench for the bridge identity and command header
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module bridge_command_id_header_tb_top;
  localparam logic [15:0] maker_code = 16'h3c3c; // arbitrary value
  localparam logic [15:0] part_code = 16'h0a17; // arbitrary value
  logic sys_clk, rst, cfg_req, cfg_we, cfg_ack, pri_req_valid, sec_req_valid, sec_req_nonposted;
  logic up_forward, ur_reply, req_dropped, pri_claim, intx_msg_valid, intx_msg_assert;
  logic master_poison_flag, system_error_sent;
  logic [9:0] cfg_dw_addr;
  logic [3:0] cfg_be, own_irq_level, sec_intx_level, intx_state;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [2:0] hit, exp3;
  wire logic [2:0] sends;
  logic [1:0] sec_req_kind, dev_en, intx_msg_lane;
  logic [6:0] ev;
  wire logic [5:0] cmd_bits;
  int n_mismatch = 0;
  int checks = 0;

  bridge_command_id_header #(.maker_identity(maker_code), .part_identity(part_code)) dut (
    .sys_clk(sys_clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .pri_req_valid(pri_req_valid), .io_window_hit(hit[0]),
    .mem_window_hit(hit[1]), .prefetch_window_hit(hit[2]), .pri_claim(pri_claim),
    .sec_req_valid(sec_req_valid), .sec_req_kind(sec_req_kind),
    .sec_req_nonposted(sec_req_nonposted), .up_forward(up_forward), .ur_reply(ur_reply),
    .req_dropped(req_dropped), .poisoned_cpl_rx(ev[6]), .poisoned_wr_tx(ev[5]),
    .own_fatal_det(ev[4]), .own_nonfatal_det(ev[3]), .dev_fatal_report_en(dev_en[1]),
    .dev_nonfatal_report_en(dev_en[0]), .sec_err_cor_rx(ev[2]),
    .sec_err_nonfatal_rx(ev[1]), .sec_err_fatal_rx(ev[0]), .err_cor_send(sends[2]),
    .err_nonfatal_send(sends[1]), .err_fatal_send(sends[0]),
    .own_irq_level(own_irq_level), .sec_intx_level(sec_intx_level),
    .intx_state(intx_state), .intx_msg_valid(intx_msg_valid),
    .intx_msg_assert(intx_msg_assert), .intx_msg_lane(intx_msg_lane),
    .io_space_respond_en(cmd_bits[0]), .mem_space_respond_en(cmd_bits[1]),
    .request_forward_en(cmd_bits[2]), .poison_report_en(cmd_bits[3]),
    .error_report_en(cmd_bits[4]), .legacy_irq_mask(cmd_bits[5]),
    .master_poison_flag(master_poison_flag), .system_error_sent(system_error_sent)
  );
  root_complex_model rc (
    .sys_clk(sys_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req),
    .cfg_we(cfg_we), .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata)
  );

  // ----------------------------------------------------------------
  // access, event and wrap-up tasks
  // ----------------------------------------------------------------
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    rc.access(1'b0, a, 4'h0, 32'h0000_0000, q);
    `CHK("cfg_rdata", e, q)
  endtask
  task automatic wr(input logic [9:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    rc.access(1'b1, a, be, d, q);
  endtask
  task automatic fire(input logic [6:0] e);
    @(negedge sys_clk);
    ev = e;
    @(negedge sys_clk);
    ev = 7'h00;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    rst = 1'b1;
    {pri_req_valid, hit, sec_req_valid, sec_req_kind, sec_req_nonposted} = 8'h00;
    ev = 7'h00;
    dev_en = 2'b00;
    own_irq_level = 4'h0;
    sec_intx_level = 4'h0;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    rd(10'h000, {part_code, maker_code});
    rd(10'h001, 32'h0000_0000);
    wr(10'h000, 4'hf, 32'hffff_ffff);
    rd(10'h000, {part_code, maker_code});
    wr(10'h001, 4'h3, 32'h0000_ffff);
    rd(10'h001, 32'h0000_0547);
    `CHK("cmd_bits", 6'h3f, cmd_bits)
    rd(10'h3ff, 32'h0000_0000);
    // window hit inputs stand for windows already programmed
    for (int e = 0; e < 4; e++)
    begin
      wr(10'h001, 4'h3, 32'(e));
      for (int j = 0; j < 3; j++)
      begin
        @(negedge sys_clk);
        pri_req_valid = 1'b1;
        hit = 3'b001 << j;
        #1;
        `CHK("pri_claim", (j == 0) ? e[0] : e[1], pri_claim)
      end
    end
    for (int f = 0; f < 2; f++)
    begin
      wr(10'h001, 4'h3, 32'(f * 4));
      for (int k = 0; k < 8; k++)
      begin
        @(negedge sys_clk);
        sec_req_valid = 1'b1;
        sec_req_kind = k[2:1];
        sec_req_nonposted = k[0];
        exp3 = {k[2] | f[0], ~k[2] & k[0] & ~f[0], ~k[2] & ~k[0] & ~f[0]};
        #1;
        `CHK("gate", exp3, {up_forward, ur_reply, req_dropped})
      end
    end
    wr(10'h001, 4'h3, 32'h0000_0000);
    fire(7'h40);
    `CHK("master_poison_flag", 1'b0, master_poison_flag)
    wr(10'h001, 4'h3, 32'h0000_0040);
    fire(7'h20);
    rd(10'h001, 32'h0100_0040);
    wr(10'h001, 4'h8, 32'h0100_0000);
    rd(10'h001, 32'h0000_0040);
    wr(10'h001, 4'h3, 32'h0000_0000);
    fire(7'h05);
    `CHK("err_send", 3'b100, sends)
    dev_en = 2'b10;
    fire(7'h10);
    `CHK("err_send", 3'b001, sends)
    `CHK("system_error_sent", 1'b0, system_error_sent)
    wr(10'h001, 4'h3, 32'h0000_0100);
    fire(7'h12);
    `CHK("err_send", 3'b011, sends)
    `CHK("system_error_sent", 1'b1, system_error_sent)
    rd(10'h001, 32'h4000_0100);
    wr(10'h001, 4'h8, 32'h4000_0000);
    rd(10'h001, 32'h0000_0100);
    wr(10'h001, 4'h3, 32'h0000_0000);
    own_irq_level = 4'h5;
    @(negedge sys_clk);
    `CHK("intx_msg", 4'hc, {intx_msg_valid, intx_msg_assert, intx_msg_lane})
    repeat (4) @(negedge sys_clk);
    `CHK("intx_state", 4'h5, intx_state)
    wr(10'h001, 4'h3, 32'h0000_0400);
    @(negedge sys_clk);
    `CHK("intx_msg", 4'h8, {intx_msg_valid, intx_msg_assert, intx_msg_lane})
    repeat (5) @(negedge sys_clk);
    `CHK("intx_state", 4'h0, intx_state)
    sec_intx_level = 4'h2;
    repeat (6) @(negedge sys_clk);
    `CHK("intx_state", 4'h2, intx_state)
    wrap_up();
  end
endmodule
`default_nettype wire
